// *** shdp_pkg.sv ***
// shared constants and types for the scsi host dma port
// assumes a single 20 MHz core clock and an active-low async reset
//
// Overview of operation
// - strap level at reset release fixes bus mode: 0 single bus, 1 split bus
// - single bus: processor bus idle, registers and dma data share dma bus
// - split bus: processor bus carries only register access, dma uses dma bus
// - split bus: register access accepted while dma transfer runs
// - every internal register reachable from register port; fifo only while no dma transfer runs
// - dma traffic uses eight data lines plus one parity line
// - dma direction comes from the executing command only
// - dma read data driven only while acknowledge is asserted
// - bytes move between scsi bus and the 16-byte fifo or buffer
// - arbitration, selection and reselection run without processor help
// - scam arbitration drives no id bit on the scsi data bus
// - selection answered late in target role while own id is unconfirmed
// - scam selection detected in hardware; answered with busy only in target role
// - parity bit travels through the fifo with its byte
// - device works as initiator or target
`default_nettype none
package shdp_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   // scsi timing figures and derived cycle counts
   localparam int ARB_DELAY_NS = 2400;
   localparam int SEL_SETTLE_NS = 1200;
   localparam int SLOW_RESP_NS = 4000;
   localparam int SCAM_DET_NS = 1000;
   localparam logic [7:0] ARB_CYC = 8'((ARB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] SEL_CYC = 8'((SEL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] SLOW_CYC = 8'((SLOW_RESP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] SCAM_CYC = 8'((SCAM_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // bus modes from the strap
   localparam logic MODE_SINGLE = 1'b0;
   localparam logic MODE_SPLIT = 1'b1;
   // register indices on the register port
   localparam logic [2:0] REG_FIFO = 3'h0;
   localparam logic [2:0] REG_CMD = 3'h1;
   localparam logic [2:0] REG_STAT = 3'h2;
   localparam logic [2:0] REG_CFG = 3'h3;
   localparam logic [2:0] REG_TGT = 3'h4;
   localparam logic [2:0] REG_FCNT = 3'h5;
   // config field positions and reset values
   localparam int CFG_ROLE_BIT = 3;
   localparam int CFG_UNCONF_BIT = 4;
   localparam int CFG_MODE_BIT = 7;
   localparam logic [2:0] OWN_ID_RST = 3'h7;
   // status flag positions
   localparam int ST_DONE = 0;
   localparam int ST_LOST = 1;
   localparam int ST_SEL = 2;
   localparam int ST_SCAM = 3;
   localparam int ST_ILL = 4;
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ABORT = 3'h1,
      CMD_XFER_OUT = 3'h2,
      CMD_XFER_IN = 3'h3,
      CMD_SELECT = 3'h4,
      CMD_RESELECT = 3'h5,
      CMD_SCAM_ARB = 3'h6
   } shdp_cmd_t;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_ARB = 6'h02,
      S_SEL = 6'h04,
      S_WAIT = 6'h08,
      S_SLOW = 6'h10,
      S_CONN = 6'h20
   } shdp_seq_t;
endpackage : shdp_pkg
`default_nettype wire

// *** shdp_fifo_if.sv ***
// fifo connection between the port logic and its byte fifo
// assumes one clock domain; pushes and pops are one-cycle strobes
`default_nettype none
interface shdp_fifo_if #(parameter int W = 9, parameter int AW = 4);
   logic push;
   logic [W-1:0] push_data;
   logic pop;
   logic [W-1:0] head;
   logic full;
   logic empty;
   logic [AW:0] count;
   modport owner (input push, input push_data, input pop,
      output head, output full, output empty, output count);
   modport user (output push, output push_data, output pop,
      input head, input full, input empty, input count);
endinterface : shdp_fifo_if
`default_nettype wire

// *** shdp_fifo.sv ***
// byte fifo that keeps the parity bit with each byte
// assumes the user never pushes when full nor pops when empty
`default_nettype none
module shdp_fifo #(
   parameter int DEPTH = 16,
   parameter int W = 9,
   parameter int AW = 4
) (
   input wire logic core_clk,
   input wire logic rstn,
   shdp_fifo_if.owner f
);
   import shdp_pkg::*;
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } shdp_fst_t;
   shdp_fst_t st_r, st_nxt;
   logic do_push, do_pop;

   // storage and pointers; byte and parity stored as one word
   always_comb begin
      st_nxt = st_r;
      do_push = f.push && (st_r.cnt != (AW+1)'(DEPTH));
      do_pop = f.pop && (st_r.cnt != '0);
      if (do_push) begin
         st_nxt.mem[st_r.wp] = f.push_data;
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (do_pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // status toward the user
   assign f.head = st_r.mem[st_r.rp];
   assign f.full = (st_r.cnt == (AW+1)'(DEPTH));
   assign f.empty = (st_r.cnt == '0);
   assign f.count = st_r.cnt;
endmodule : shdp_fifo
`default_nettype wire

// *** shdp_top.sv ***
// scsi host dma port: register port, dma port, scsi sequencer, fifo
// assumes all inputs synchronous to core_clk; scsi pins given as logic levels
`default_nettype none
module shdp_top (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic bus_mode_strap,
   input wire logic cpu_cs,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [2:0] cpu_addr,
   input wire logic [7:0] proc_data_in,
   output logic [7:0] proc_data_out,
   output logic proc_data_oe,
   input wire logic [7:0] dma_data_lines_in,
   output logic [7:0] dma_data_lines_out,
   output logic dma_data_lines_oe,
   input wire logic dma_bus_parity_in,
   output logic dma_bus_parity_out,
   output logic dma_bus_parity_oe,
   input wire logic dma_acknowledge,
   input wire logic dma_write_strobe,
   output logic dma_request,
   input wire logic scsi_bsy_in,
   output logic scsi_bsy_out,
   output logic scsi_bsy_oe,
   input wire logic scsi_sel_in,
   output logic scsi_sel_out,
   output logic scsi_sel_oe,
   output logic scsi_io_out,
   output logic scsi_io_oe,
   input wire logic [7:0] scsi_db_in,
   output logic [7:0] scsi_db_out,
   output logic scsi_db_oe,
   input wire logic scsi_rx_valid,
   input wire logic [7:0] scsi_rx_data,
   input wire logic scsi_rx_par,
   output logic scsi_rx_ready,
   output logic scsi_tx_valid,
   output logic [7:0] scsi_tx_data,
   output logic scsi_tx_par,
   input wire logic scsi_tx_ready
);
   import shdp_pkg::*;
   typedef struct packed {
      logic mode;
      logic mode_ok;
      shdp_seq_t seq;
      logic [7:0] cnt;
      logic scam;
      logic resel;
      logic xfer_on;
      logic to_scsi;
      logic role_tgt;
      logic unconf;
      logic [2:0] own_id;
      logic [2:0] tgt_id;
      logic [4:0] stat;
      logic [7:0] rdata;
      logic rd_d;
      logic [2:0] addr_d;
      logic dma_acknowledge_d;
   } shdp_st_t;
   shdp_st_t st_r, st_nxt;
   shdp_fifo_if #(.W(9), .AW(FIFO_AW)) fio ();

   logic [7:0] wdata, own_bit, tgt_bit, rd_val;
   logic wr_cmd, rd_end, bus_free, dma_wr, dma_rd_end, cpu_fifo_ok;
   shdp_cmd_t cmd;

   // one-hot id bit on the scsi data bus
   function automatic logic [7:0] id_bit(input logic [2:0] id);
      id_bit = 8'h01 << id;
   endfunction : id_bit

   shdp_fifo #(.DEPTH(FIFO_DEPTH), .W(9), .AW(FIFO_AW)) u_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .f(fio.owner)
   );

   // register port decode; data source follows the bus mode
   always_comb begin
      wdata = (st_r.mode == MODE_SPLIT) ? proc_data_in : dma_data_lines_in;
      cmd = shdp_cmd_t'(wdata[2:0]);
      wr_cmd = cpu_cs && cpu_wr && st_r.mode_ok;
      rd_end = st_r.rd_d && !(cpu_cs && cpu_rd);
      own_bit = id_bit(st_r.own_id);
      tgt_bit = id_bit(st_r.tgt_id);
      bus_free = !scsi_bsy_in && !scsi_sel_in;
      cpu_fifo_ok = !st_r.xfer_on;
      dma_wr = dma_acknowledge && dma_write_strobe && st_r.xfer_on && st_r.to_scsi;
      dma_rd_end = st_r.dma_acknowledge_d && !dma_acknowledge && st_r.xfer_on && !st_r.to_scsi;
      case (cpu_addr)
         REG_FIFO: rd_val = fio.head[7:0];
         REG_STAT: rd_val = {3'h0, st_r.stat};
         REG_CFG: rd_val = {st_r.mode, 2'h0, st_r.unconf, st_r.role_tgt, st_r.own_id};
         REG_TGT: rd_val = {5'h0, st_r.tgt_id};
         REG_FCNT: rd_val = {3'h0, fio.count};
         default: rd_val = 8'h00;
      endcase
   end

   // fifo sources and sinks: dma and scsi stream per direction, plus the register port while no transfer runs
   always_comb begin
      scsi_rx_ready = st_r.xfer_on && !st_r.to_scsi && !fio.full;
      scsi_tx_valid = st_r.xfer_on && st_r.to_scsi && !fio.empty;
      fio.push = dma_wr || (scsi_rx_valid && scsi_rx_ready)
         || (wr_cmd && cpu_addr == REG_FIFO && cpu_fifo_ok);
      if (dma_wr) begin
         fio.push_data = {dma_bus_parity_in, dma_data_lines_in};
      end else if (st_r.xfer_on) begin
         fio.push_data = {scsi_rx_par, scsi_rx_data};
      end else begin
         fio.push_data = {^wdata, wdata};
      end
      fio.pop = (scsi_tx_valid && scsi_tx_ready) || dma_rd_end
         || (rd_end && st_r.addr_d == REG_FIFO && cpu_fifo_ok);
   end

   // sequencer, command and status next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_d = cpu_cs && cpu_rd;
      st_nxt.addr_d = cpu_addr;
      st_nxt.dma_acknowledge_d = dma_acknowledge;
      st_nxt.rdata = rd_val;
      if (!st_r.mode_ok) begin
         st_nxt.mode = bus_mode_strap;
         st_nxt.mode_ok = 1'b1;
      end
      // status read clears only the bits it reported; a new event wins
      if (rd_end && st_r.addr_d == REG_STAT) begin
         st_nxt.stat = st_r.stat & ~st_r.rdata[4:0];
      end
      st_nxt.cnt = st_r.cnt + 8'h01;
      case (st_r.seq)
         S_IDLE: begin
            st_nxt.cnt = 8'h00;
            if (scsi_sel_in && !scsi_bsy_in && (scsi_db_in & own_bit) != 8'h00) begin
               st_nxt.stat[ST_SEL] = 1'b1;
               st_nxt.seq = st_r.unconf ? S_SLOW : S_CONN;
            end else if (scsi_sel_in && !scsi_bsy_in && scsi_db_in == 8'h00) begin
               st_nxt.cnt = st_r.cnt + 8'h01;
               if (st_r.cnt == SCAM_CYC - 8'h01) begin
                  st_nxt.stat[ST_SCAM] = 1'b1;
                  st_nxt.seq = S_CONN;
               end
            end
         end
         S_ARB: begin
            if (st_r.cnt == ARB_CYC - 8'h01) begin
               st_nxt.cnt = 8'h00;
               if (!st_r.scam && (scsi_db_in & ~((own_bit << 1) - 8'h01)) != 8'h00) begin
                  st_nxt.stat[ST_LOST] = 1'b1;
                  st_nxt.seq = S_IDLE;
               end else begin
                  st_nxt.seq = S_SEL;
               end
            end
         end
         S_SEL: begin
            if (st_r.cnt == SEL_CYC - 8'h01) begin
               st_nxt.seq = S_WAIT;
            end
         end
         S_WAIT: begin
            if (scsi_bsy_in) begin
               st_nxt.stat[ST_DONE] = 1'b1;
               st_nxt.seq = S_CONN;
            end
         end
         S_SLOW: begin
            if (!scsi_sel_in) begin
               st_nxt.seq = S_IDLE;
            end else if (st_r.cnt == SLOW_CYC - 8'h01) begin
               st_nxt.seq = S_CONN;
            end
         end
         S_CONN: st_nxt.cnt = 8'h00;
         default: st_nxt.seq = S_IDLE;
      endcase
      if (wr_cmd) begin
         case (cpu_addr)
            REG_CMD: begin
               case (cmd)
                  CMD_ABORT: begin
                     st_nxt.xfer_on = 1'b0;
                     st_nxt.seq = S_IDLE;
                  end
                  CMD_XFER_OUT, CMD_XFER_IN: begin
                     st_nxt.xfer_on = 1'b1;
                     st_nxt.to_scsi = (cmd == CMD_XFER_OUT);
                  end
                  CMD_SELECT, CMD_RESELECT, CMD_SCAM_ARB: begin
                     // role picks which of select and reselect is legal
                     if (st_r.seq != S_IDLE || !bus_free
                        || (cmd == CMD_SELECT && st_r.role_tgt)
                        || (cmd == CMD_RESELECT && !st_r.role_tgt)) begin
                        st_nxt.stat[ST_ILL] = 1'b1;
                     end else begin
                        st_nxt.seq = S_ARB;
                        st_nxt.cnt = 8'h00;
                        st_nxt.scam = (cmd == CMD_SCAM_ARB);
                        st_nxt.resel = (cmd == CMD_RESELECT);
                     end
                  end
                  default: ;
               endcase
            end
            REG_CFG: begin
               st_nxt.own_id = wdata[2:0];
               st_nxt.role_tgt = wdata[CFG_ROLE_BIT];
               st_nxt.unconf = wdata[CFG_UNCONF_BIT];
            end
            REG_TGT: st_nxt.tgt_id = wdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '{mode: MODE_SINGLE, seq: S_IDLE, own_id: OWN_ID_RST, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // register port drivers; processor bus silent in single mode
   assign proc_data_out = st_r.rdata;
   assign proc_data_oe = st_r.mode_ok && st_r.mode == MODE_SPLIT && cpu_cs && cpu_rd;
   // dma bus carries fifo data under acknowledge, else register reads
   assign dma_data_lines_out = dma_acknowledge ? fio.head[7:0] : st_r.rdata;
   assign dma_bus_parity_out = dma_acknowledge ? fio.head[8] : ^st_r.rdata;
   assign dma_data_lines_oe = (dma_acknowledge && st_r.xfer_on && !st_r.to_scsi)
      || (st_r.mode_ok && st_r.mode == MODE_SINGLE && cpu_cs && cpu_rd && !dma_acknowledge);
   assign dma_bus_parity_oe = dma_data_lines_oe;
   assign dma_request = st_r.xfer_on && (st_r.to_scsi ? !fio.full : !fio.empty);
   assign scsi_tx_data = fio.head[7:0];
   assign scsi_tx_par = fio.head[8];
   // scsi control pins, asserted level given as 1
   assign scsi_bsy_out = 1'b1;
   assign scsi_bsy_oe = (st_r.seq == S_ARB) || (st_r.seq == S_SEL)
      || (st_r.seq == S_CONN && st_r.role_tgt);
   assign scsi_sel_out = 1'b1;
   assign scsi_sel_oe = (st_r.seq == S_SEL) || (st_r.seq == S_WAIT);
   assign scsi_io_out = 1'b1;
   assign scsi_io_oe = st_r.resel && scsi_sel_oe;
   assign scsi_db_out = (st_r.seq == S_ARB) ? (st_r.scam ? 8'h00 : own_bit)
      : (st_r.scam ? 8'h00 : own_bit | tgt_bit);
   assign scsi_db_oe = ((st_r.seq == S_ARB) && !st_r.scam) || scsi_sel_oe;

   sequence s_slow_start;
      st_r.seq == S_IDLE && st_nxt.seq == S_SLOW;
   endsequence
   sequence s_arb_end;
      st_r.seq == S_ARB && st_nxt.seq != S_ARB && !(wr_cmd && cmd == CMD_ABORT && cpu_addr == REG_CMD);
   endsequence

   property p_strap_fixed;
      @(posedge core_clk) disable iff (!rstn) st_r.mode_ok |=> $stable(st_r.mode);
   endproperty
   a_strap_fixed: assert property (p_strap_fixed) else $error("bus mode changed");
   property p_proc_quiet;
      @(posedge core_clk) disable iff (!rstn) st_r.mode == MODE_SINGLE |-> !proc_data_oe;
   endproperty
   a_proc_quiet: assert property (p_proc_quiet) else $error("proc bus driven");
   property p_dma_release;
      @(posedge core_clk) disable iff (!rstn)
         (st_r.mode == MODE_SPLIT && !dma_acknowledge) |-> !dma_data_lines_oe;
   endproperty
   a_dma_release: assert property (p_dma_release) else $error("dma bus held");
   property p_dreq;
      @(posedge core_clk) disable iff (!rstn)
         dma_request |-> st_r.xfer_on && (st_r.to_scsi ? fio.count != 5'd16 : fio.count != 0);
   endproperty
   a_dreq: assert property (p_dreq) else $error("dma request wrong");
   property p_dma_push;
      @(posedge core_clk) disable iff (!rstn)
         dma_wr && !fio.full && !fio.pop |=> fio.count == $past(fio.count) + 5'd1;
   endproperty
   a_dma_push: assert property (p_dma_push) else $error("dma byte lost");
   property p_arb_len;
      @(posedge core_clk) disable iff (!rstn) s_arb_end |-> st_r.cnt == ARB_CYC - 8'h01;
   endproperty
   a_arb_len: assert property (p_arb_len) else $error("arbitration too short");
   property p_scam_noid;
      @(posedge core_clk) disable iff (!rstn) st_r.seq == S_ARB && st_r.scam |-> !scsi_db_oe;
   endproperty
   a_scam_noid: assert property (p_scam_noid) else $error("id driven in scam");
   property p_slow;
      @(posedge core_clk) disable iff (!rstn) s_slow_start |=> !scsi_bsy_oe [*8];
   endproperty
   a_slow: assert property (p_slow) else $error("selection answered early");
   property p_scam_resp;
      @(posedge core_clk) disable iff (!rstn)
         $rose(st_r.stat[ST_SCAM]) && st_r.role_tgt |-> scsi_bsy_oe;
   endproperty
   a_scam_resp: assert property (p_scam_resp) else $error("scam selection ignored");
endmodule : shdp_top
`default_nettype wire

// *** shdp_dma_model.sv ***
// dma controller model standing on the dma bus of the host dma port
// assumes the bench sets go, dir, wval and gap at the falling edge
`default_nettype none
module shdp_dma_model (
   input wire logic core_clk,
   input wire logic dma_request,
   input wire logic [7:0] dma_data_lines_out,
   input wire logic dma_bus_parity_out,
   input wire logic go,
   input wire logic dir,
   input wire logic [8:0] wval,
   input wire logic [1:0] gap,
   output logic dma_acknowledge,
   output logic dma_write_strobe,
   output logic [8:0] m_wd,
   output logic [8:0] rval,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ns;
   // one access per request; released lines show the inverted last byte
   initial begin
      {dma_acknowledge, dma_write_strobe, done, m_wd, rval} = '0;
      forever begin
         @(posedge core_clk);
         if (go && dma_request) begin
            repeat (gap + 1) @(negedge core_clk);
            dma_acknowledge = 1'b1;
            if (!dir) begin
               m_wd = wval;
               dma_write_strobe = 1'b1;
            end
            @(posedge core_clk);
            rval = {dma_bus_parity_out, dma_data_lines_out};
            @(negedge core_clk);
            dma_write_strobe = 1'b0;
            dma_acknowledge = 1'b0;
            m_wd = ~m_wd;
            done = 1'b1;
            @(negedge core_clk);
            done = 1'b0;
         end
      end
   end
endmodule : shdp_dma_model
`default_nettype wire

// *** shdp_top_tb.sv ***
// self-checking bench for the scsi host dma port
// assumes the dma model; scsi far side driven only with stream handshakes, a target busy, an own-id selection and a scam selection
`default_nettype none
module shdp_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import shdp_pkg::*;
   logic core_clk = 1'b0, rstn, bus_mode_strap, cpu_cs, cpu_rd, cpu_wr, dma_acknowledge;
   logic [2:0] cpu_addr;
   logic [7:0] proc_data_in, proc_data_out, dma_data_lines_in, dma_data_lines_out, r;
   logic [7:0] scsi_db_in, scsi_db_out, scsi_rx_data, scsi_tx_data, cpu_wd;
   logic proc_data_oe, dma_data_lines_oe, dma_bus_parity_in, dma_bus_parity_out;
   logic dma_bus_parity_oe, dma_write_strobe, dma_request, scsi_bsy_in, scsi_bsy_out;
   logic scsi_bsy_oe, scsi_sel_in, scsi_sel_out, scsi_sel_oe, scsi_io_out, scsi_io_oe;
   logic scsi_db_oe, scsi_rx_valid, scsi_rx_par, scsi_rx_ready, scsi_tx_valid, scsi_tx_par;
   logic scsi_tx_ready, cpu_bus, go, dir, done;
   logic [1:0] gap;
   logic [8:0] wval, m_wd, rval, v;
   logic [8:0] tq[$];
   logic [8:0] dq[$];
   int fails = 0, compares = 0, i;
   // clock
   always #25 core_clk = ~core_clk;
   // shared dma bus: host in single mode, otherwise the model
   assign dma_data_lines_in = cpu_bus ? cpu_wd : m_wd[7:0];
   assign dma_bus_parity_in = cpu_bus ? ^cpu_wd : m_wd[8];
   shdp_top DUT (.core_clk, .rstn, .bus_mode_strap, .cpu_cs, .cpu_rd, .cpu_wr, .cpu_addr,
      .proc_data_in, .proc_data_out, .proc_data_oe, .dma_data_lines_in, .dma_data_lines_out,
      .dma_data_lines_oe, .dma_bus_parity_in, .dma_bus_parity_out, .dma_bus_parity_oe,
      .dma_acknowledge, .dma_write_strobe, .dma_request, .scsi_bsy_in, .scsi_bsy_out,
      .scsi_bsy_oe, .scsi_sel_in, .scsi_sel_out, .scsi_sel_oe, .scsi_io_out, .scsi_io_oe,
      .scsi_db_in, .scsi_db_out, .scsi_db_oe, .scsi_rx_valid, .scsi_rx_data, .scsi_rx_par,
      .scsi_rx_ready, .scsi_tx_valid, .scsi_tx_data, .scsi_tx_par, .scsi_tx_ready);
   shdp_dma_model dma_m (.core_clk, .dma_request, .dma_data_lines_out, .dma_bus_parity_out,
      .go, .dir, .wval, .gap, .dma_acknowledge, .dma_write_strobe, .m_wd, .rval, .done);
   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_reg
   task automatic chk_byte(input string n, input logic [8:0] e, input logic [8:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_byte
   task automatic tmo(input int k, input int n);
      if (k >= n) begin
         fails++;
         $display("[FAIL] wait expected %0d cycles seen more", n);
         wrap_up();
      end
   endtask : tmo
   task automatic do_reset(input logic m);
      @(negedge core_clk);
      rstn = 1'b0;
      bus_mode_strap = m;
      repeat (8) @(negedge core_clk);
      chk_reg("reset_outs", 8'h00, {proc_data_oe, dma_data_lines_oe, dma_bus_parity_oe,
         scsi_bsy_oe, scsi_sel_oe, scsi_db_oe, dma_request, scsi_tx_valid});
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
   endtask : do_reset
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {cpu_cs, cpu_wr, cpu_addr, proc_data_in, cpu_wd} = {2'b11, a, d, d};
      cpu_bus = !bus_mode_strap;
      @(negedge core_clk);
      {cpu_cs, cpu_wr, cpu_bus} = 3'b000;
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge core_clk);
      {cpu_cs, cpu_rd, cpu_addr} = {2'b11, a};
      @(negedge core_clk);
      d = bus_mode_strap ? proc_data_out : dma_data_lines_out;
      chk_reg("read_oe", {6'h00, bus_mode_strap, !bus_mode_strap},
         {6'h00, proc_data_oe, dma_data_lines_oe});
      {cpu_cs, cpu_rd} = 2'b00;
   endtask : reg_rd
   task automatic dma_op(input logic d, input logic [8:0] val);
      int k;
      @(negedge core_clk);
      {go, dir, wval, gap} = {1'b1, d, val, 2'($urandom_range(0, 3))};
      for (k = 0; k < 100 && done !== 1'b1; k++) @(posedge core_clk);
      tmo(k, 100);
      @(negedge core_clk);
      go = 1'b0;
   endtask : dma_op
   task automatic rx_byte(input logic [8:0] val);
      int k;
      {scsi_rx_par, scsi_rx_data} = val;
      scsi_rx_valid = 1'b1;
      for (k = 0; k < 50 && scsi_rx_ready !== 1'b1; k++) @(negedge core_clk);
      tmo(k, 50);
      @(negedge core_clk);
   endtask : rx_byte
   task automatic wait_bsy;
      int k;
      for (k = 0; k < 10 && scsi_bsy_oe !== 1'b1; k++) @(negedge core_clk);
      tmo(k, 10);
   endtask : wait_bsy
   // compares stream bytes and dma reads against the oldest note
   always @(posedge core_clk) begin
      if (scsi_tx_valid === 1'b1 && scsi_tx_ready === 1'b1) begin
         if (tq.size() == 0) chk_byte("tx_extra", 9'h000, 9'h1FF);
         else chk_byte("tx_byte", tq.pop_front(), {scsi_tx_par, scsi_tx_data});
      end
      if (done === 1'b1 && dir === 1'b1 && go === 1'b1) begin
         if (dq.size() == 0) chk_byte("dma_extra", 9'h000, 9'h1FF);
         else chk_byte("dma_rd", dq.pop_front(), rval);
      end
      if (bus_mode_strap && rstn && dma_data_lines_oe === 1'b1 && !dma_acknowledge)
         chk_reg("dma_oe_no_ack", 8'h00, 8'h01);
   end
   // main sequence
   initial begin
      {rstn, cpu_cs, cpu_rd, cpu_wr, cpu_addr, proc_data_in, cpu_wd, cpu_bus} = '0;
      {scsi_bsy_in, scsi_sel_in, scsi_db_in, scsi_rx_valid, scsi_rx_data} = '0;
      {scsi_rx_par, scsi_tx_ready, go, dir, wval, gap} = '0;
      bus_mode_strap = 1'b1;
      void'($urandom(79142));
      do_reset(1'b1);
      reg_rd(REG_CFG, r);
      chk_reg("cfg_reset", 8'h87, r);
      reg_wr(REG_CFG, 8'h05);
      reg_rd(REG_CFG, r);
      chk_reg("cfg_mode_ro", 8'h85, r);
      reg_wr(REG_FIFO, 8'h5A);
      reg_rd(REG_FCNT, r);
      chk_reg("fcnt_one", 8'h01, r);
      reg_rd(REG_FIFO, r);
      chk_reg("fifo_reg", 8'h5A, r);
      reg_wr(REG_CMD, {5'h00, CMD_XFER_OUT});
      @(negedge core_clk);
      chk_reg("dreq_out_empty", 8'h01, {7'h00, dma_request});
      for (i = 0; i < FIFO_DEPTH; i++) begin
         v = 9'($urandom());
         tq.push_back(v);
         if (i == 7) fork
            dma_op(1'b0, v);
            reg_rd(REG_CFG, r);
         join
         else dma_op(1'b0, v);
      end
      chk_reg("cfg_during_dma", 8'h85, r);
      @(negedge core_clk);
      chk_reg("dreq_full", 8'h00, {7'h00, dma_request});
      reg_rd(REG_FCNT, r);
      chk_reg("fcnt_full", 8'h10, r);
      for (i = 0; i < 400 && tq.size() > 0; i++) begin
         @(negedge core_clk);
         scsi_tx_ready = 1'($urandom());
      end
      tmo(i, 400);
      @(negedge core_clk);
      scsi_tx_ready = 1'b0;
      reg_wr(REG_CMD, {5'h00, CMD_ABORT});
      reg_wr(REG_CMD, {5'h00, CMD_XFER_IN});
      @(negedge core_clk);
      chk_reg("dreq_in_empty", 8'h00, {7'h00, dma_request});
      for (i = 0; i < FIFO_DEPTH; i++) begin
         v = 9'($urandom());
         dq.push_back(v);
         rx_byte(v);
      end
      scsi_rx_valid = 1'b0;
      for (i = 0; i < FIFO_DEPTH; i++) dma_op(1'b1, 9'h000);
      @(negedge core_clk);
      chk_reg("dreq_drained", 8'h00, {7'h00, dma_request});
      chk_reg("dma_left", 8'h00, 8'(dq.size()));
      reg_wr(REG_CMD, {5'h00, CMD_ABORT});
      reg_wr(REG_CMD, {5'h00, CMD_SELECT});
      wait_bsy();
      chk_reg("arb_id", 8'h20, scsi_db_oe ? scsi_db_out : 8'h00);
      for (i = 0; i < 120 && scsi_sel_oe !== 1'b1; i++) @(negedge core_clk);
      tmo(i, 120);
      scsi_bsy_in = 1'b1;
      for (i = 0; i < 40; i++) begin
         reg_rd(REG_STAT, r);
         if (r[ST_DONE] === 1'b1) break;
      end
      chk_reg("sel_done", 8'h01, {7'h00, r[ST_DONE]});
      reg_wr(REG_CMD, {5'h00, CMD_ABORT});
      scsi_bsy_in = 1'b0;
      reg_wr(REG_CMD, {5'h00, CMD_SCAM_ARB});
      wait_bsy();
      chk_reg("scam_no_id", 8'h00, {7'h00, scsi_db_oe});
      reg_wr(REG_CMD, {5'h00, CMD_ABORT});
      // target role, unconfirmed id 5: late answer to selection, then scam selection
      reg_wr(REG_CFG, 8'h1D);
      scsi_db_in = 8'h20;
      scsi_sel_in = 1'b1;
      for (i = 0; i < 100 && scsi_bsy_oe !== 1'b1; i++) @(negedge core_clk);
      tmo(i, 100);
      chk_reg("slow_resp", SLOW_CYC + 8'h01, 8'(i));
      reg_rd(REG_STAT, r);
      chk_reg("stat_sel", 8'h04, r);
      scsi_db_in = 8'h00;
      reg_wr(REG_CMD, {5'h00, CMD_ABORT});
      for (i = 0; i < 40 && scsi_bsy_oe !== 1'b1; i++) @(negedge core_clk);
      tmo(i, 40);
      reg_wr(REG_CMD, {5'h00, CMD_SELECT});
      reg_rd(REG_STAT, r);
      chk_reg("stat_scam_ill", 8'h18, r);
      scsi_sel_in = 1'b0;
      do_reset(1'b0);
      reg_rd(REG_CFG, r);
      chk_reg("cfg_single", 8'h07, r);
      reg_wr(REG_TGT, 8'h03);
      reg_rd(REG_TGT, r);
      chk_reg("tgt_single", 8'h03, r);
      wrap_up();
   end
endmodule : shdp_top_tb
`default_nettype wire
